// *** rtl/pmr_pkg.sv ***
// Purpose: Constants and types shared by the mode and regulator control block
// Assumes: Register data words are 24 bits wide, bits 7:0 ignored on write and read as zero
// Notes: Register indices are local selection codes on the access port
package pmr_pkg;

  // ****************************************************************
  // Register selection and data
  // ****************************************************************
  localparam int unsigned DATA_W = 24;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned RAIL_N = 7;
  localparam int unsigned TSD_N = 6;
  localparam logic [ADDR_W-1:0] IDX_MAIN_MODE = 2'h0;
  localparam logic [ADDR_W-1:0] IDX_ONOFF_REQ = 2'h1;
  localparam logic [ADDR_W-1:0] IDX_SLEW_CFG = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 24'h00_0000;

  // ****************************************************************
  // Mode register fields
  // ****************************************************************
  localparam int unsigned BIT_PLL_LOCK = 16;
  localparam int unsigned BIT_EXT_SEL_RT = 15;
  localparam int unsigned BIT_EXT_SEL_DIS = 14;
  localparam int unsigned BIT_MAIN_NORMAL = 13;
  localparam int unsigned BIT_WAKE_TWO_DIS = 10;
  localparam int unsigned BIT_WAKE_ONE_DIS = 9;
  localparam int unsigned BIT_STANDBY_REQ = 8;

  // ****************************************************************
  // On/off request register fields
  // ****************************************************************
  localparam int unsigned BIT_PD_OFF = 23;
  localparam int unsigned LSB_OFF_REQ = 16;
  localparam int unsigned LSB_ON_REQ = 8;
  localparam int unsigned RAIL_PREREG = 6;
  localparam logic [RAIL_N-1:0] RAIL_EN_RST = 7'h7f;

  // ****************************************************************
  // Slew and thermal configuration fields
  // ****************************************************************
  localparam int unsigned LSB_BOOST_SLEW = 22;
  localparam int unsigned LSB_TSD = 16;
  localparam int unsigned LSB_LS_DRIVE = 11;
  localparam int unsigned LSB_HS_DRIVE = 8;
  localparam logic [1:0] BOOST_SLEW_RST = 2'h0;
  localparam logic [TSD_N-1:0] TSD_RST = 6'h00;
  localparam logic [1:0] LS_DRIVE_RST = 2'h3;
  localparam logic [1:0] HS_DRIVE_RST = 2'h0;

  // Boost slew codes, 50/100/300/500 V/us
  typedef enum logic [1:0] {
    PMR_SLEW_50 = 2'h0,
    PMR_SLEW_100 = 2'h1,
    PMR_SLEW_300 = 2'h2,
    PMR_SLEW_500 = 2'h3
  } pmr_slew_t;

  // Gate drive codes, 130/260/520/900 mA
  typedef enum logic [1:0] {
    PMR_DRV_130 = 2'h0,
    PMR_DRV_260 = 2'h1,
    PMR_DRV_520 = 2'h2,
    PMR_DRV_900 = 2'h3
  } pmr_drive_t;

endpackage

// *** rtl/pmr_rail_if.sv ***
// Purpose: Request and state carrier between the control top and one rail
// Assumes: Requests are one-cycle pulses
// Notes: The rail end returns its enable level
interface pmr_rail_if;
  logic on_req;
  logic off_req;
  logic rail_en;

  modport ctrl (output on_req, output off_req, input rail_en);
  modport rail (input on_req, input off_req, output rail_en);
endinterface

// *** rtl/pmr_rail_ctrl.sv ***
// Purpose: Enable state of one regulator, driven by on and off pulses
// Assumes: Pulses come from the register write logic
// Notes: REENABLE_ONLY makes the on pulse act only after an off pulse
module pmr_rail_ctrl #(
  parameter bit REENABLE_ONLY = 1'b0,
  parameter bit EN_RST = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Request side
  pmr_rail_if.rail bus
);
  import pmr_pkg::*;

  logic was_disabled;

  // Off wins over a simultaneous on
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus.rail_en <= EN_RST;
      was_disabled <= 1'b0;
    end else if (bus.off_req) begin
      bus.rail_en <= 1'b0;
      was_disabled <= 1'b1;
    end else if (bus.on_req && (!REENABLE_ONLY || was_disabled)) begin
      bus.rail_en <= 1'b1;
      was_disabled <= 1'b0;
    end
  end

endmodule

// *** rtl/pmr_mode_regctrl.sv ***
// Purpose: Mode register and two regulator control registers of the main domain
// Assumes: Access strobes are one-cycle pulses synchronous to clk_i
// Notes: Read data and acknowledge come one cycle after the strobe
//
// Behaviour
// - Writing bit 14 requests external clock deselect
// - Bit 13 reads normal-mode status
// - Bit 10 stored, disables second wake
// - Bit 9 stored, disables first wake
// - Writing bit 8 requests standby
// - Bit 23 stored, forces pre-regulator pull-down off
// - Bits 22..16 request regulator disables
// - Bits 14..8 request regulator enables
// - Pre-regulator enable acts only after disable
// - Boost slew code selects 50..500 V/us
// - Power-on reset restores defaults
// - Thermal bit one adds deep fail-safe
// - Low-side drive code selects 130..900 mA
// - High-side drive code selects 130..900 mA
module pmr_mode_regctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register access port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [pmr_pkg::ADDR_W-1:0] reg_idx_i,
  input wire logic [pmr_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [pmr_pkg::DATA_W-1:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_err_o,
  // Status from the device
  input wire logic main_normal_i,
  input wire logic pll_lock_i,
  input wire logic ext_clk_selected_i,
  // OTP configuration load
  input wire logic otp_load_i,
  input wire logic [1:0] otp_boost_slew_i,
  input wire logic [pmr_pkg::TSD_N-1:0] otp_thermal_action_i,
  input wire logic [1:0] otp_highside_drive_i,
  // Mode controls
  output logic ext_clock_select_disable_o,
  output logic standby_request_o,
  output logic wake_in_one_disable_o,
  output logic wake_in_two_disable_o,
  // Regulator controls
  output logic [pmr_pkg::RAIL_N-1:0] rail_en_o,
  output logic prereg_pulldown_off_o,
  output pmr_pkg::pmr_slew_t boost_slew_select_o,
  output logic [pmr_pkg::TSD_N-1:0] thermal_action_o,
  output pmr_pkg::pmr_drive_t prereg_lowside_drive_o,
  output pmr_pkg::pmr_drive_t prereg_highside_drive_o
);
  import pmr_pkg::*;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic wr_mode;
  logic wr_onoff;
  logic wr_cfg;
  logic idx_ok;
  logic [RAIL_N-1:0] on_pulse;
  logic [RAIL_N-1:0] off_pulse;
  logic [RAIL_N-1:0] rail_en;
  logic [DATA_W-1:0] next_rdata;

  // Register selection
  assign wr_mode = reg_wr_i && (reg_idx_i == IDX_MAIN_MODE);
  assign wr_onoff = reg_wr_i && (reg_idx_i == IDX_ONOFF_REQ);
  assign wr_cfg = reg_wr_i && (reg_idx_i == IDX_SLEW_CFG);
  assign idx_ok = (reg_idx_i == IDX_MAIN_MODE) || (reg_idx_i == IDX_ONOFF_REQ)
                  || (reg_idx_i == IDX_SLEW_CFG);

  // ****************************************************************
  // Mode register
  // ****************************************************************

  // Single-shot mode requests
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_clock_select_disable_o <= 1'b0;
      standby_request_o <= 1'b0;
    end else begin
      ext_clock_select_disable_o <= wr_mode && reg_wdata_i[BIT_EXT_SEL_DIS];
      standby_request_o <= wr_mode && reg_wdata_i[BIT_STANDBY_REQ];
    end
  end

  // Stored wake disables
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_in_one_disable_o <= 1'b0;
      wake_in_two_disable_o <= 1'b0;
    end else if (wr_mode) begin
      wake_in_two_disable_o <= reg_wdata_i[BIT_WAKE_TWO_DIS];
      wake_in_one_disable_o <= reg_wdata_i[BIT_WAKE_ONE_DIS];
    end
  end

  // ****************************************************************
  // On/off request register
  // ****************************************************************

  // Request pulses and pull-down override
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      on_pulse <= '0;
      off_pulse <= '0;
      prereg_pulldown_off_o <= 1'b0;
    end else begin
      off_pulse <= wr_onoff ? reg_wdata_i[LSB_OFF_REQ +: RAIL_N] : '0;
      on_pulse <= wr_onoff ? reg_wdata_i[LSB_ON_REQ +: RAIL_N] : '0;
      if (wr_onoff) begin
        prereg_pulldown_off_o <= reg_wdata_i[BIT_PD_OFF];
      end
    end
  end

  // One rail controller per regulator, index 6 is the pre-regulator
  pmr_rail_if rail_if[RAIL_N] ();
  generate
    for (genvar g = 0; g < RAIL_N; g++) begin : g_rail
      assign rail_if[g].on_req = on_pulse[g];
      assign rail_if[g].off_req = off_pulse[g];
      assign rail_en[g] = rail_if[g].rail_en;
      pmr_rail_ctrl #(
        .REENABLE_ONLY(g == RAIL_PREREG),
        .EN_RST(RAIL_EN_RST[g])
      ) u_rail (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .bus(rail_if[g])
      );
    end
  endgenerate

  // Rail enables out through a register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rail_en_o <= RAIL_EN_RST;
    end else begin
      rail_en_o <= rail_en;
    end
  end

  // ****************************************************************
  // Slew and thermal configuration
  // ****************************************************************

  // OTP load wins over a host write in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boost_slew_select_o <= pmr_slew_t'(BOOST_SLEW_RST);
      thermal_action_o <= TSD_RST;
      prereg_lowside_drive_o <= pmr_drive_t'(LS_DRIVE_RST);
      prereg_highside_drive_o <= pmr_drive_t'(HS_DRIVE_RST);
    end else if (otp_load_i) begin
      boost_slew_select_o <= pmr_slew_t'(otp_boost_slew_i);
      thermal_action_o <= otp_thermal_action_i;
      prereg_highside_drive_o <= pmr_drive_t'(otp_highside_drive_i);
    end else if (wr_cfg) begin
      boost_slew_select_o <= pmr_slew_t'(reg_wdata_i[LSB_BOOST_SLEW +: 2]);
      thermal_action_o <= reg_wdata_i[LSB_TSD +: TSD_N];
      prereg_lowside_drive_o <= pmr_drive_t'(reg_wdata_i[LSB_LS_DRIVE +: 2]);
      prereg_highside_drive_o <= pmr_drive_t'(reg_wdata_i[LSB_HS_DRIVE +: 2]);
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************

  // Read mux, request bits and reserved positions read zero
  always_comb begin
    next_rdata = DATA_ZERO;
    unique case (reg_idx_i)
      IDX_MAIN_MODE: begin
        next_rdata[BIT_PLL_LOCK] = pll_lock_i;
        next_rdata[BIT_EXT_SEL_RT] = ext_clk_selected_i;
        next_rdata[BIT_MAIN_NORMAL] = main_normal_i;
        next_rdata[BIT_WAKE_TWO_DIS] = wake_in_two_disable_o;
        next_rdata[BIT_WAKE_ONE_DIS] = wake_in_one_disable_o;
      end
      IDX_ONOFF_REQ: begin
        next_rdata[BIT_PD_OFF] = prereg_pulldown_off_o;
      end
      IDX_SLEW_CFG: begin
        next_rdata[LSB_BOOST_SLEW +: 2] = boost_slew_select_o;
        next_rdata[LSB_TSD +: TSD_N] = thermal_action_o;
        next_rdata[LSB_LS_DRIVE +: 2] = prereg_lowside_drive_o;
        next_rdata[LSB_HS_DRIVE +: 2] = prereg_highside_drive_o;
      end
      default: begin
        next_rdata = DATA_ZERO;
      end
    endcase
  end

  // Registered answer to every access
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= DATA_ZERO;
      reg_ack_o <= 1'b0;
      reg_err_o <= 1'b0;
    end else begin
      reg_ack_o <= reg_wr_i || reg_rd_i;
      reg_err_o <= (reg_wr_i || reg_rd_i) && !idx_ok;
      reg_rdata_o <= reg_rd_i ? next_rdata : DATA_ZERO;
    end
  end

endmodule

// *** verification/pmr_mode_regctrl_sva.sv ***
// Purpose: Assertions on the register port and control outputs
// Assumes: Strobes are one-cycle pulses, answer one cycle later
// Notes: Bound to the top module
module pmr_mode_regctrl_sva (
  // Clock, reset and access
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [pmr_pkg::ADDR_W-1:0] reg_idx_i,
  input wire logic [pmr_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic main_normal_i,
  // Observed outputs
  input wire logic [pmr_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic reg_ack_o,
  input wire logic reg_err_o,
  input wire logic ext_clock_select_disable_o,
  input wire logic standby_request_o,
  input wire logic wake_in_one_disable_o,
  input wire logic [pmr_pkg::RAIL_N-1:0] rail_en_o,
  input wire logic prereg_pulldown_off_o
);
  import pmr_pkg::*;
  // ********
  // Access decode and properties
  // ********
  logic wr_mode;
  logic rd_mode;
  logic wr_onoff;
  assign wr_mode = reg_wr_i && reg_idx_i == IDX_MAIN_MODE;
  assign rd_mode = reg_rd_i && reg_idx_i == IDX_MAIN_MODE;
  assign wr_onoff = reg_wr_i && reg_idx_i == IDX_ONOFF_REQ;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_ext_sel;
    wr_mode |=> ext_clock_select_disable_o == $past(reg_wdata_i[14]);
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("ext select pulse wrong");
  property p_normal;
    rd_mode |=> reg_rdata_o[13] == $past(main_normal_i);
  endproperty
  a_normal: assert property (p_normal) else $error("normal status wrong");
  property p_wake_one;
    wr_mode |=> wake_in_one_disable_o == $past(reg_wdata_i[9]);
  endproperty
  a_wake_one: assert property (p_wake_one) else $error("wake one disable wrong");
  property p_standby;
    wr_mode |=> standby_request_o == $past(reg_wdata_i[8]);
  endproperty
  a_standby: assert property (p_standby) else $error("standby pulse wrong");
  property p_pulldown;
    wr_onoff |=> prereg_pulldown_off_o == $past(reg_wdata_i[23]);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown level wrong");
  property p_rail_off;
    wr_onoff |-> ##3 (rail_en_o & $past(reg_wdata_i[22:16], 3)) == 7'h00;
  endproperty
  a_rail_off: assert property (p_rail_off) else $error("rail not switched off");
  property p_onoff_read;
    reg_rd_i && reg_idx_i == IDX_ONOFF_REQ |=> reg_rdata_o[22:0] == 23'h00_0000;
  endproperty
  a_onoff_read: assert property (p_onoff_read) else $error("request bits read back");
  property p_unmapped;
    (reg_wr_i || reg_rd_i) && reg_idx_i == 2'h3 |=> reg_err_o && reg_ack_o && reg_rdata_o == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answer wrong");
endmodule

bind pmr_mode_regctrl pmr_mode_regctrl_sva u_sva (.clk_i, .rstn_i, .reg_wr_i, .reg_rd_i,
  .reg_idx_i, .reg_wdata_i, .main_normal_i, .reg_rdata_o, .reg_ack_o, .reg_err_o,
  .ext_clock_select_disable_o, .standby_request_o, .wake_in_one_disable_o, .rail_en_o,
  .prereg_pulldown_off_o);

// *** verification/pmr_host_model.sv ***
// Purpose: Host side issuing single register accesses
// Assumes: One access at a time, strobe one cycle long
// Notes: Released data lines show inverted values
module pmr_host_model (
  // Clock
  input wire logic clk_i,
  // Access port toward the block
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [pmr_pkg::ADDR_W-1:0] reg_idx_o,
  output logic [pmr_pkg::DATA_W-1:0] reg_wdata_o,
  input wire logic [pmr_pkg::DATA_W-1:0] reg_rdata_i,
  input wire logic reg_ack_i
);
  import pmr_pkg::*;
  // ********
  // Access task
  // ********
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_idx_o = '0;
    reg_wdata_o = '0;
  end
  task automatic access(input logic wr, input logic [ADDR_W-1:0] idx,
                        input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata);
    int n;
    @(posedge clk_i);
    reg_wr_o <= wr;
    reg_rd_o <= !wr;
    reg_idx_o <= idx;
    reg_wdata_o <= wdata;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (reg_ack_i !== 1'b1 && n < 8);
    rdata = reg_rdata_i;
    reg_wdata_o <= ~wdata; // Released only once the answer is taken
    @(negedge clk_i);
  endtask
endmodule

// *** verification/pmr_mode_regctrl_tb.sv ***
// Purpose: Register-level tests of the mode and regulator control block
// Assumes: Host model issues every access
// Notes: Control outputs are looked at on the falling edge, read data and acknowledge on the rising edge
module pmr_mode_regctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmr_pkg::*;
  // ********
  // Signals, instances and tasks
  // ********
  logic clk_i;
  logic rstn_i = 1'b0;
  logic reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o, otp_load_i = 1'b0;
  logic main_normal_i = 1'b1, pll_lock_i = 1'b1, ext_clk_selected_i = 1'b1;
  logic [ADDR_W-1:0] reg_idx_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  logic [1:0] otp_boost_slew_i = 2'h0, otp_highside_drive_i = 2'h0;
  logic [TSD_N-1:0] otp_thermal_action_i = 6'h00, thermal_action_o;
  logic ext_clock_select_disable_o, standby_request_o, prereg_pulldown_off_o;
  logic wake_in_one_disable_o, wake_in_two_disable_o;
  logic [RAIL_N-1:0] rail_en_o;
  pmr_slew_t boost_slew_select_o;
  pmr_drive_t prereg_lowside_drive_o, prereg_highside_drive_o;
  logic [14:0] cfg_view;
  int n_fail = 0, n_compared = 0, cycles = 0;
  assign cfg_view = {wake_in_two_disable_o, wake_in_one_disable_o, prereg_pulldown_off_o,
    boost_slew_select_o, thermal_action_o, prereg_lowside_drive_o, prereg_highside_drive_o};
  pmr_mode_regctrl uut (.clk_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_idx_i, .reg_wdata_i,
    .reg_rdata_o, .reg_ack_o, .reg_err_o, .main_normal_i, .pll_lock_i, .ext_clk_selected_i,
    .otp_load_i, .otp_boost_slew_i, .otp_thermal_action_i, .otp_highside_drive_i,
    .ext_clock_select_disable_o, .standby_request_o, .wake_in_one_disable_o,
    .wake_in_two_disable_o, .rail_en_o, .prereg_pulldown_off_o, .boost_slew_select_o,
    .thermal_action_o, .prereg_lowside_drive_o, .prereg_highside_drive_o);
  pmr_host_model host (.clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_idx_o(reg_idx_i),
    .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o), .reg_ack_i(reg_ack_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [DATA_W-1:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    host.access(1'b1, idx, d, r);
    @(negedge clk_i); // Rail enables settle two cycles after the answer
  endtask
  task automatic rd(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] exp, input string s);
    logic [DATA_W-1:0] r;
    host.access(1'b0, idx, '0, r);
    check(s, exp, r);
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    check("rails", 24'(RAIL_EN_RST), 24'(rail_en_o));
    check("cfg", 24'({3'b000, BOOST_SLEW_RST, TSD_RST, LS_DRIVE_RST, HS_DRIVE_RST}), 24'(cfg_view));
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ********
  // Main sequence
  // ********
  initial begin
    logic [DATA_W-1:0] d;
    do_reset();
    rd(IDX_MAIN_MODE, 24'h01_a000, "mode");
    wr(IDX_MAIN_MODE, 24'h00_4700);
    check("wake", 24'h3, 24'({wake_in_two_disable_o, wake_in_one_disable_o}));
    @(posedge clk_i);
    main_normal_i <= 1'b0;
    rd(IDX_MAIN_MODE, 24'h01_8600, "mode");
    wr(IDX_MAIN_MODE, 24'h00_0400);
    check("wake", 24'h2, 24'({wake_in_two_disable_o, wake_in_one_disable_o}));
    wr(IDX_ONOFF_REQ, 24'hff_7f00);
    check("rails", 24'h00, 24'(rail_en_o));
    rd(IDX_ONOFF_REQ, 24'h80_0000, "onoff");
    wr(IDX_ONOFF_REQ, 24'h80_3f00);
    check("rails", 24'h3f, 24'(rail_en_o));
    wr(IDX_ONOFF_REQ, 24'h00_4000);
    check("rails", 24'h7f, 24'(rail_en_o));
    check("pulldown", 24'h0, 24'(prereg_pulldown_off_o));
    for (int i = 0; i < 4; i++) begin
      d = {2'(i), 6'h15 ^ 6'(i), 3'b000, 2'(i), 1'b0, 2'(3 - i), 8'h00};
      wr(IDX_SLEW_CFG, d ^ 24'h00_04ff);
      rd(IDX_SLEW_CFG, d, "cfg");
      check("cfg", 24'({3'b100, 2'(i), 6'h15 ^ 6'(i), 2'(i), 2'(3 - i)}), 24'(cfg_view));
    end
    @(posedge clk_i);
    otp_boost_slew_i <= 2'h2;
    otp_thermal_action_i <= 6'h2a;
    otp_highside_drive_i <= 2'h1;
    otp_load_i <= 1'b1;
    @(posedge clk_i);
    otp_load_i <= 1'b0;
    @(negedge clk_i);
    check("otp", 24'({3'b100, 2'h2, 6'h2a, 2'h3, 2'h1}), 24'(cfg_view));
    rd(2'h3, 24'h00_0000, "unmapped");
    do_reset();
    rd(IDX_ONOFF_REQ, 24'h00_0000, "onoff");
    end_of_test();
  end
endmodule
